// file: verilog/dual_gpio_port.sv
// Dual GPIO port (7-bit port C, 8-bit port D) with pullups and APB registers
// What this block does
// [R01] Port C data read gives latch where direction is 1, pin level where 0.
// [R02] Data writes always update the latch; input pins keep reading the pin.
// [R03] Port D data read gives latch for output bits, live pin for inputs.
// [R04] Port C pullup on only when enabled and pin is an input.
// [R05] Port C has seven writable pullup enables, 1 connects, 0 disconnects.
// [R06] Port D has eight writable pullup enables, active while pin is not driven by GPIO or a peripheral.
// [R07] Port D direction 1 drives latch onto pin; 0 leaves pin high impedance.
// [R08] Reset clears all port D direction bits.
// [R09] Reset leaves the port D data latch unchanged.
// [R10] Timer edge/level selects choose timer channel or GPIO on two port D pins, 6 and 7.
// [R11] With SPI disabled, SPI pins of port D are ordinary GPIO.
// [R12] SPI-owned pins take drive from SPI; direction still selects read source.
// [R13] Slave select is GPIO if SPI off or master; else SPI drives it and direction only selects the read source.
// [R14] Software should write the latch before turning a pin to output.
// [R15] Reset clears port C direction bits, leaves port C latch unchanged.
// [R16] Bit 7 of port C registers ignores writes and reads zero.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "gpio_map.svh"
module dual_gpio_port
  import gpio_pkg::*;
(
  input wire logic ref_clk, // System clock, 10 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire gpio_pkg::apb_addr_t paddr, // APB byte address
  input wire gpio_pkg::apb_word_t pwdata, // APB write data
  output gpio_pkg::apb_word_t prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire gpio_pkg::port_byte_t port_c_pin_in, // Port C pin levels (bit 7 unused)
  output gpio_pkg::port_byte_t port_c_pin_out, // Port C drive values
  output gpio_pkg::port_byte_t port_c_pin_oe, // Port C output enables
  output gpio_pkg::port_byte_t port_c_pullup_on, // Port C active pullups
  input wire gpio_pkg::port_byte_t port_d_pin_in, // Port D pin levels
  output gpio_pkg::port_byte_t port_d_pin_out, // Port D drive values
  output gpio_pkg::port_byte_t port_d_pin_oe, // Port D output enables
  output gpio_pkg::port_byte_t port_d_pullup_on, // Port D active pullups
  input wire gpio_pkg::port_byte_t spi_pin_out, // SPI drive values on bits 3..0
  input wire gpio_pkg::port_byte_t spi_pin_oe, // SPI output enables on bits 3..0
  input wire gpio_pkg::port_byte_t timer_pin_out, // Timer drive values on bits 7..6
  input wire gpio_pkg::port_byte_t timer_pin_oe, // Timer output enables on bits 7..6
  output logic spi_enable_bit, // SPI enable, to the SPI
  output logic spi_master_select_bit, // SPI master mode, to the SPI
  output logic [3:0] timer_channel_active // Channel owns pin: TIMER_TWO_CHANNEL_ONE,TIMER_TWO_CHANNEL_ZERO,TIMER_ONE_CHANNEL_ONE,TIMER_ONE_CHANNEL_ZERO
);
  port_byte_t c_sync;
  port_byte_t d_sync;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  port_byte_t port_c_data_latch;
  port_byte_t port_d_data_latch;
  port_byte_t port_c_direction;
  port_byte_t port_d_direction;
  port_byte_t port_c_pullup_enables;
  port_byte_t port_d_pullup_enables;
  logic [`CTRL_WIDTH-1:0] share_ctrl;
  port_byte_t next_port_c_data_latch;
  port_byte_t next_port_d_data_latch;
  port_byte_t next_port_c_direction;
  port_byte_t next_port_d_direction;
  port_byte_t next_port_c_pullup_enables;
  port_byte_t next_port_d_pullup_enables;
  logic [`CTRL_WIDTH-1:0] next_share_ctrl;
  apb_word_t next_prdata;
  logic next_pready;
  logic next_pslverr;
  port_byte_t next_c_out;
  port_byte_t next_c_oe;
  port_byte_t next_c_pu;
  port_byte_t next_d_out;
  port_byte_t next_d_oe;
  port_byte_t next_d_pu;
  logic [3:0] next_timer_active;
  logic access;
  logic mapped;
  apb_addr_t reg_idx;

  // ----------------------------------------------------------------
  // Register map, word index = byte address / 4
  // ----------------------------------------------------------------
  // 0x002 port C data: latch on write, latch/pin mix on read
  // 0x003 port D data: latch on write, latch/pin mix on read
  // 0x004 port C direction: 1 drives the pin
  // 0x005 port D direction: 1 drives unless a peripheral owns the pin
  // 0x006 port C pullup enables: honoured only on input pins
  // 0x007 port D pullup enables: honoured only on undriven pins
  // 0x008 sharing control: SPI enable, SPI master, four timer selects
  // Any other index, or a byte offset inside a word, answers with an error
  // Data latches carry no reset value, so software must write them first
  // Registers live in the low byte of each bus word; upper bits read zero
  // Port C bit 7 has no pin: it never stores, drives or reads back
  // Pin reads lag the pads by two clocks through the synchronisers

  // Read mux: latch for output bits, synchronised pin for input bits
  function automatic port_byte_t read_port(input port_byte_t latch, input port_byte_t dir,
    input port_byte_t pins);
    read_port = (latch & dir) | (pins & ~dir);
  endfunction

  // Port C has seven pins; the missing bit is cut everywhere it is stored or read
  function automatic port_byte_t port_c_bits(input port_byte_t value);
    port_c_bits = value & `PORT_C_MASK; // [R16]
  endfunction

  // A register byte placed in a bus word
  function automatic apb_word_t widen(input port_byte_t value);
    widen = {24'h00_0000, value};
  endfunction

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  pin_sync sync_c
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in(port_c_pin_in),
    .pin_sync_out(c_sync)
  );

  pin_sync sync_d
  (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pin_in(port_d_pin_in),
    .pin_sync_out(d_sync)
  );

  // ----------------------------------------------------------------
  // APB register access
  // ----------------------------------------------------------------
  // Address decode; a byte offset inside a word never maps to a register
  always_comb
  begin
    access = psel && penable && !pready;
    reg_idx = {2'b00, paddr[11:2]};
    mapped = (paddr[1:0] == 2'b00) && (reg_idx >= `PORT_C_DATA_IDX) && (reg_idx <= `SHARE_CTRL_IDX);
  end

  // One-wait slave: pready rises one edge after the first access cycle, for one cycle
  always_comb
  begin
    next_port_c_data_latch = port_c_data_latch;
    next_port_d_data_latch = port_d_data_latch;
    next_port_c_direction = port_c_direction;
    next_port_d_direction = port_d_direction;
    next_port_c_pullup_enables = port_c_pullup_enables;
    next_port_d_pullup_enables = port_d_pullup_enables;
    next_share_ctrl = share_ctrl;
    next_prdata = 32'h0000_0000;
    next_pready = access;
    next_pslverr = access && !mapped;
    if (access && mapped && pwrite)
    begin
      // Latch writes regardless of direction; input pins still read the pin
      case (reg_idx)
        `PORT_C_DATA_IDX: next_port_c_data_latch = port_c_bits(pwdata[7:0]); // [R02] [R16]
        `PORT_D_DATA_IDX: next_port_d_data_latch = pwdata[7:0]; // [R02]
        `PORT_C_DIR_IDX: next_port_c_direction = port_c_bits(pwdata[7:0]); // [R16]
        `PORT_D_DIR_IDX: next_port_d_direction = pwdata[7:0];
        `PORT_C_PUE_IDX: next_port_c_pullup_enables = port_c_bits(pwdata[7:0]); // [R05] [R16]
        `PORT_D_PUE_IDX: next_port_d_pullup_enables = pwdata[7:0]; // [R06]
        `SHARE_CTRL_IDX: next_share_ctrl = pwdata[`CTRL_WIDTH-1:0];
        default: next_share_ctrl = share_ctrl;
      endcase
    end
    if (access && mapped && !pwrite)
    begin
      case (reg_idx)
        `PORT_C_DATA_IDX: next_prdata =
          widen(port_c_bits(read_port(port_c_data_latch, port_c_direction, c_sync))); // [R01] [R16]
        `PORT_D_DATA_IDX: next_prdata =
          widen(read_port(port_d_data_latch, port_d_direction, d_sync)); // [R03] [R12]
        `PORT_C_DIR_IDX: next_prdata = widen(port_c_direction);
        `PORT_D_DIR_IDX: next_prdata = widen(port_d_direction);
        `PORT_C_PUE_IDX: next_prdata = widen(port_c_pullup_enables);
        `PORT_D_PUE_IDX: next_prdata = widen(port_d_pullup_enables);
        `SHARE_CTRL_IDX: next_prdata = {26'h000_0000, share_ctrl};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Directions and controls reset; data latches hold across reset by design
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      port_c_direction <= `DIR_RESET; // [R15]
      port_d_direction <= `DIR_RESET; // [R08]
      port_c_pullup_enables <= `PUE_RESET;
      port_d_pullup_enables <= `PUE_RESET;
      share_ctrl <= `CTRL_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      port_c_direction <= next_port_c_direction;
      port_d_direction <= next_port_d_direction;
      port_c_pullup_enables <= next_port_c_pullup_enables;
      port_d_pullup_enables <= next_port_d_pullup_enables;
      share_ctrl <= next_share_ctrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Data latches have no reset; contents survive a system reset
  always_ff @(posedge ref_clk)
  begin
    port_c_data_latch <= next_port_c_data_latch; // [R09] [R15]
    port_d_data_latch <= next_port_d_data_latch; // [R09]
  end

  // ----------------------------------------------------------------
  // Pin drive and pullup control
  // ----------------------------------------------------------------
  // Port C has no sharing: direction alone decides drive and pullup
  always_comb
  begin
    next_c_out = port_c_bits(port_c_data_latch);
    next_c_oe = port_c_bits(port_c_direction);
    next_c_pu = port_c_bits(port_c_pullup_enables & ~port_c_direction); // [R04]
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      port_c_pin_out <= 8'h00;
      port_c_pin_oe <= 8'h00;
      port_c_pullup_on <= 8'h00;
    end
    else
    begin
      port_c_pin_out <= next_c_out;
      port_c_pin_oe <= next_c_oe;
      port_c_pullup_on <= next_c_pu;
    end
  end

  // Peripheral ownership overrides direction for drive only, never for reads
  always_comb
  begin
    next_timer_active[0] = share_ctrl[`CTRL_TIMER_ONE_CHANNEL_ZERO_BIT];
    next_timer_active[1] = share_ctrl[`CTRL_TIMER_ONE_CHANNEL_ONE_BIT];
    next_timer_active[2] = share_ctrl[`CTRL_TIMER_TWO_CHANNEL_ZERO_BIT];
    next_timer_active[3] = share_ctrl[`CTRL_TIMER_TWO_CHANNEL_ONE_BIT];
    next_d_out = port_d_data_latch; // [R07]
    next_d_oe = port_d_direction; // [R07] [R11]
    // Timer channels: pins 6,7 shared by both timers; either active takes over
    if (next_timer_active[0] || next_timer_active[2])
    begin
      next_d_out[6] = timer_pin_out[6]; // [R10]
      next_d_oe[6] = timer_pin_oe[6]; // [R10]
    end
    if (next_timer_active[1] || next_timer_active[3])
    begin
      next_d_out[7] = timer_pin_out[7]; // [R10]
      next_d_oe[7] = timer_pin_oe[7]; // [R10]
    end
    if (share_ctrl[`CTRL_SPI_EN_BIT])
    begin
      // Clock, MOSI and MISO follow the SPI whenever it is enabled
      next_d_out[3:1] = spi_pin_out[3:1]; // [R12]
      next_d_oe[3:1] = spi_pin_oe[3:1]; // [R12]
      if (!share_ctrl[`CTRL_SPI_MSTR_BIT])
      begin
        next_d_out[0] = spi_pin_out[0]; // [R13]
        next_d_oe[0] = spi_pin_oe[0]; // [R13]
      end
    end
    // Pullup only while the pin is not being driven
    next_d_pu = port_d_pullup_enables & ~next_d_oe; // [R06]
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      port_d_pin_out <= 8'h00;
      port_d_pin_oe <= 8'h00;
      port_d_pullup_on <= 8'h00;
      spi_enable_bit <= 1'b0;
      spi_master_select_bit <= 1'b0;
      timer_channel_active <= 4'h0;
    end
    else
    begin
      port_d_pin_out <= next_d_out;
      port_d_pin_oe <= next_d_oe;
      port_d_pullup_on <= next_d_pu;
      spi_enable_bit <= share_ctrl[`CTRL_SPI_EN_BIT]; // [R11]
      spi_master_select_bit <= share_ctrl[`CTRL_SPI_MSTR_BIT];
      timer_channel_active <= next_timer_active;
    end
  end
endmodule

// file: verilog/gpio_map.svh
// Register offsets, field positions and reset values for the dual GPIO port block
`ifndef GPIO_MAP_SVH
`define GPIO_MAP_SVH

// ----------------------------------------------------------------
// Register indices and byte addresses (byte = 4 * index)
// ----------------------------------------------------------------
`define PORT_C_DATA_IDX 12'h002
`define PORT_D_DATA_IDX 12'h003
`define PORT_C_DIR_IDX 12'h004
`define PORT_D_DIR_IDX 12'h005
`define PORT_C_PUE_IDX 12'h006
`define PORT_D_PUE_IDX 12'h007
`define SHARE_CTRL_IDX 12'h008

// ----------------------------------------------------------------
// Field positions in the pin sharing control register
// ----------------------------------------------------------------
`define CTRL_SPI_EN_BIT 0
`define CTRL_SPI_MSTR_BIT 1
`define CTRL_TIMER_ONE_CHANNEL_ZERO_BIT 2
`define CTRL_TIMER_ONE_CHANNEL_ONE_BIT 3
`define CTRL_TIMER_TWO_CHANNEL_ZERO_BIT 4
`define CTRL_TIMER_TWO_CHANNEL_ONE_BIT 5
`define CTRL_WIDTH 6

// ----------------------------------------------------------------
// Reset values and widths
// ----------------------------------------------------------------
`define PORT_C_MASK 8'h7f
`define DIR_RESET 8'h00
`define PUE_RESET 8'h00
`define CTRL_RESET 6'h00
`define LATCH_INIT 8'h00

`endif

// file: verilog/gpio_pkg.sv
// Types shared by the dual GPIO port block
package gpio_pkg;
  typedef logic [7:0] port_byte_t;
  typedef logic [31:0] apb_word_t;
  typedef logic [11:0] apb_addr_t;
endpackage

// file: verilog/pin_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels
`timescale 1ns/100ps
module pin_sync
  import gpio_pkg::*;
(
  input wire logic ref_clk, // System clock
  input wire logic rstn, // Asynchronous reset, active low
  input wire gpio_pkg::port_byte_t pin_in, // Raw pin levels
  output gpio_pkg::port_byte_t pin_sync_out // Synchronised levels
);
  port_byte_t stage_one;
  port_byte_t next_stage_one;
  port_byte_t next_sync_out;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // First stage feeds only the second stage, keeping metastability contained
  always_comb
  begin
    next_stage_one = pin_in;
    next_sync_out = stage_one;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage_one <= 8'h00;
      pin_sync_out <= 8'h00;
    end
    else
    begin
      stage_one <= next_stage_one;
      pin_sync_out <= next_sync_out;
    end
  end
endmodule

// file: tb/gpio_monitor.sv
// Concurrent checks on the ports of the dual GPIO port block
`timescale 1ns/100ps
module gpio_monitor
  import gpio_pkg::*;
(
  input wire logic ref_clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire gpio_pkg::apb_word_t prdata, // Read data
  input wire gpio_pkg::port_byte_t port_c_pin_oe, // C drive
  input wire gpio_pkg::port_byte_t port_c_pullup_on, // C pullups
  input wire gpio_pkg::port_byte_t port_d_pin_oe, // D drive
  input wire gpio_pkg::port_byte_t port_d_pullup_on, // D pullups
  input wire gpio_pkg::port_byte_t spi_pin_oe, // SPI drive
  input wire gpio_pkg::port_byte_t timer_pin_oe, // Timer drive
  input wire logic spi_enable_bit, // SPI on
  input wire logic spi_master_select_bit, // SPI master
  input wire logic [3:0] timer_channel_active // Timer owns pin
);
  // ------------------------------------------------------------
  // Checks, all on the one clock
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Owner must be stable a cycle, since pin drive is registered behind it
  sequence s_take; psel && penable && !pready; endsequence
  sequence s_spi_held; spi_enable_bit && $past(spi_enable_bit); endsequence
  sequence s_ss_held; s_spi_held ##0 (!spi_master_select_bit && !$past(spi_master_select_bit)); endsequence
  sequence s_t6_held; timer_channel_active[0] && $past(timer_channel_active[0]); endsequence
  a_ready_late: assert property (s_take |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
  a_err_alone: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000) else $error("prdata not idle");
  a_pullup_gated: assert property (((port_c_pullup_on & port_c_pin_oe) | (port_d_pullup_on & port_d_pin_oe)) == 8'h00)
    else $error("Pullup on driven pin");
  a_c_bit_seven: assert property (!port_c_pin_oe[7] && !port_c_pullup_on[7]) else $error("C bit 7 active");
  a_reset_inputs: assert property ($rose(rstn) |-> (port_c_pin_oe | port_d_pin_oe) == 8'h00)
    else $error("Pins driven after reset");
  a_spi_owns: assert property (s_spi_held |-> ((port_d_pin_oe ^ $past(spi_pin_oe)) & 8'h0e) == 8'h00)
    else $error("SPI pin drive wrong");
  a_ss_owns: assert property (s_ss_held |-> ((port_d_pin_oe ^ $past(spi_pin_oe)) & 8'h01) == 8'h00)
    else $error("Slave select drive wrong");
  a_timer_owns: assert property (s_t6_held |-> ((port_d_pin_oe ^ $past(timer_pin_oe)) & 8'h40) == 8'h00)
    else $error("Timer pin drive wrong");
endmodule

bind dual_gpio_port gpio_monitor mon (.ref_clk, .rstn, .psel, .penable, .pready, .pslverr, .prdata,
  .port_c_pin_oe, .port_c_pullup_on, .port_d_pin_oe, .port_d_pullup_on, .spi_pin_oe, .timer_pin_oe,
  .spi_enable_bit, .spi_master_select_bit, .timer_channel_active);

// file: tb/pin_board.sv
// Board model: resolves each pad from device drive, board drive and pullup
`timescale 1ns/100ps
module pin_board
  import gpio_pkg::*;
(
  input wire logic ref_clk, // Clock for float pattern
  input wire gpio_pkg::port_byte_t drv_out, // Device values
  input wire gpio_pkg::port_byte_t drv_oe, // Device enables
  input wire gpio_pkg::port_byte_t pull_on, // Device pullups
  input wire gpio_pkg::port_byte_t ext_val, // Board values
  input wire gpio_pkg::port_byte_t ext_en, // Board enables
  output gpio_pkg::port_byte_t pin_lvl // Pad levels
);
  port_byte_t wander = 8'h5a;
  // A floating pad toggles each cycle so nothing can rely on a stale level
  always @(posedge ref_clk) wander <= ~wander;
  // Device drive wins, then board drive, then pullup, else float
  assign pin_lvl = (drv_oe & drv_out) | (~drv_oe & ext_en & ext_val) | (~drv_oe & ~ext_en & (pull_on | wander));
endmodule

// file: tb/testbench.sv
// Self-checking bench for the dual GPIO port block
`timescale 1ns/100ps
`include "gpio_map.svh"
module testbench;
  import gpio_pkg::*;
  logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, spi_en, spi_ms, err;
  logic [3:0] tca;
  apb_addr_t paddr = 12'h000;
  apb_word_t pwdata = 32'h0000_0000, prdata, rd;
  port_byte_t c_in, c_out, c_oe, c_pu, d_in, d_out, d_oe, d_pu, eo;
  port_byte_t so = 8'h00, soe = 8'h00, to = 8'h00, toe = 8'h00, ev = 8'h00, ee = 8'hff;
  port_byte_t dq [2], lq [2], pq [2];
  port_byte_t tbl [8] = '{8'h01, 8'h03, 8'h00, 8'h04, 8'h08, 8'h10, 8'h20, 8'h3c};
  logic [31:0] seed = 32'he421ba90;
  int fail_count = 0, tests_run = 0;

  always #50 ref_clk = ~ref_clk;

  dual_gpio_port uut (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .port_c_pin_in(c_in), .port_c_pin_out(c_out), .port_c_pin_oe(c_oe), .port_c_pullup_on(c_pu),
    .port_d_pin_in(d_in), .port_d_pin_out(d_out), .port_d_pin_oe(d_oe), .port_d_pullup_on(d_pu),
    .spi_pin_out(so), .spi_pin_oe(soe), .timer_pin_out(to), .timer_pin_oe(toe),
    .spi_enable_bit(spi_en), .spi_master_select_bit(spi_ms), .timer_channel_active(tca));
  pin_board pc (.ref_clk, .drv_out(c_out), .drv_oe(c_oe), .pull_on(c_pu), .ext_val(ev), .ext_en(ee), .pin_lvl(c_in));
  pin_board pd (.ref_clk, .drv_out(d_out), .drv_oe(d_oe), .pull_on(d_pu), .ext_val(ev), .ext_en(ee), .pin_lvl(d_in));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic port_byte_t pmask(input int p);
    return (p != 0) ? 8'hff : 8'h7f;
  endfunction
  // Port D value after the SPI and timer take their pins
  function automatic port_byte_t share(input port_byte_t c, input port_byte_t g, input port_byte_t s, input port_byte_t t);
    port_byte_t r;
    r = g;
    if (c[0]) r[3:1] = s[3:1];
    if (c[0] && !c[1]) r[0] = s[0];
    if (c[2] || c[4]) r[6] = t[6];
    if (c[3] || c[5]) r[7] = t[7];
    return r;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask
  // One APB transfer; waits for pready however long it takes, the watchdog bounds it
  task automatic apb(input logic w, input int idx, input port_byte_t d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= 12'(idx * 4);
    pwdata <= {24'h000000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input int idx, input port_byte_t e);
    apb(1'b0, idx, 8'h00);
    chk("register", {24'h000000, e}, rd);
  endtask
  // Synchroniser needs two edges; four leave margin, then sample mid-cycle
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // Bits whose pad level is determined are compared, and bit 7 in every case
  task automatic check_data(input int p, input port_byte_t o, input port_byte_t v, input port_byte_t pu);
    port_byte_t kn;
    port_byte_t ex;
    kn = (dq[p] | o | ee | pu) & pmask(p);
    ex = (lq[p] & dq[p]) | (~dq[p] & ((o & v) | (~o & ee & ev) | (~o & ~ee & pu)));
    apb(1'b0, `PORT_C_DATA_IDX + p, 8'h00);
    chk("data", {24'h000000, ex & kn}, rd & {24'h000000, kn | 8'h80});
  endtask
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    dq = '{8'h00, 8'h00};
    for (int i = `PORT_C_DIR_IDX; i <= `SHARE_CTRL_IDX; i++) rdchk(i, 8'h00);
  endtask
  task automatic give_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    do_reset();
    apb(1'b1, 16'h3f, 8'hff);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped data", 32'h0, rd);
    for (int k = 0; k < 12; k++)
    begin
      for (int p = 0; p < 2; p++)
      begin
        pq[p] = rnd();
        lq[p] = rnd();
        ee <= rnd();
        ev <= rnd();
        apb(1'b1, `PORT_C_PUE_IDX + p, pq[p]);
        apb(1'b1, `PORT_C_DATA_IDX + p, lq[p]);
        settle();
        check_data(p, dq[p], lq[p], pq[p] & ~dq[p]);
        dq[p] = rnd();
        apb(1'b1, `PORT_C_DIR_IDX + p, dq[p]);
        settle();
        check_data(p, dq[p], lq[p], pq[p] & ~dq[p]);
        chk("oe", dq[p] & pmask(p), (p != 0) ? d_oe : c_oe);
        chk("pullup", pq[p] & ~dq[p] & pmask(p), (p != 0) ? d_pu : c_pu);
        chk("out", lq[p] & pmask(p), ((p != 0) ? d_out : c_out) & pmask(p));
        rdchk(`PORT_C_PUE_IDX + p, pq[p] & pmask(p));
        rdchk(`PORT_C_DIR_IDX + p, dq[p] & pmask(p));
      end
    end
    // Walk every sharing mode with random peripheral drive
    foreach (tbl[j])
    begin
      apb(1'b1, `SHARE_CTRL_IDX, tbl[j]);
      so <= rnd();
      soe <= rnd();
      to <= rnd();
      toe <= rnd();
      settle();
      eo = share(tbl[j], dq[1], soe, toe);
      chk("d oe", eo, d_oe);
      chk("d out", share(tbl[j], lq[1], so, to), d_out);
      chk("d pullup", pq[1] & ~eo, d_pu);
      chk("share bits", tbl[j], {tca, spi_ms, spi_en});
      check_data(1, eo, share(tbl[j], lq[1], so, to), pq[1] & ~eo);
    end
    // Reset in mid-run keeps both latches
    do_reset();
    for (int p = 0; p < 2; p++)
    begin
      dq[p] = 8'hff;
      apb(1'b1, `PORT_C_DIR_IDX + p, 8'hff);
      settle();
      check_data(p, dq[p], lq[p], 8'h00);
    end
    give_verdict();
  end

  // Watchdog: the sequence needs about 1100 cycles, this allows 20000
  initial
  begin
    #2_000_000;
    fail_count++;
    give_verdict();
  end
endmodule
